// *** rtl/ttr_pkg.sv ***
// Constants shared by the tone transceiver host register block.
// Assumes a 10 MHz system clock and a host that strobes accesses with phi2.
package ttr_pkg;

  // ----------------------------------------------------------------
  // Register select and read/write encodings
  // ----------------------------------------------------------------
  localparam logic RS_DATA = 1'b0;
  localparam logic RS_CTRL = 1'b1;
  localparam logic RW_WR   = 1'b0;
  localparam logic RW_RD   = 1'b1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PRI_TONE_OUT = 0;
  localparam int PRI_CP_MODE  = 1;
  localparam int PRI_IRQ_EN   = 2;
  localparam int PRI_SEL_SEC  = 3;
  localparam int SEC_BURST    = 0;
  localparam int SEC_TEST     = 1;
  localparam int SEC_SINGLE   = 2;
  localparam int SEC_COLUMN   = 3;
  localparam int ST_IRQ       = 0;
  localparam int ST_TX_READY  = 1;
  localparam int ST_RX_FULL   = 2;
  localparam int ST_STEERING  = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] CODE_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Timebase and burst timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ   = 10000000;
  localparam int XTAL_HZ  = 3579545;
  localparam int BURST_MS = 50;
  localparam int BURST_XTAL_TICKS = (BURST_MS * XTAL_HZ + 999) / 1000;
  localparam int ACC_W    = 24;
  localparam int TIMER_W  = 19;

  typedef enum logic [2:0] {
    TTR_IDLE  = 3'h1,
    TTR_TONE  = 3'h2,
    TTR_PAUSE = 3'h4
  } ttr_burst_t;

endpackage

// *** rtl/ttr_sync.sv ***
// Three-stage synchroniser with a settled-level output per bit.
// Assumes inputs are asynchronous to i_clk; a change counts when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ttr_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  initial begin
    if (W < 1) $error("ttr_sync: W must be at least 1");
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          o_q[g] <= 1'b0;
        end else begin
          s1_reg <= i_d[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            o_q[g] <= s3_reg;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** rtl/ttr_regs.sv ***
// Host register bank of a dual-tone signalling transceiver.
// Assumes a strobed host port (phi2, chip select, R/W, register select, 4-bit data)
// asynchronous to i_clk, and receiver logic on i_clk giving validation pulses.
`timescale 1ns/1ps
`default_nettype none
module ttr_regs
  import ttr_pkg::*;
#(
  parameter int BURST_TICKS = BURST_XTAL_TICKS
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_phi2,
  input  wire logic       i_cs_n,
  input  wire logic       i_rw,
  input  wire logic       i_register_select_line,
  input  wire logic [3:0] i_data,
  output logic      [3:0] o_data,
  output logic            o_data_oe,
  input  wire logic       i_rx_valid,
  input  wire logic [3:0] i_rx_code,
  input  wire logic       i_rx_absent,
  input  wire logic       i_cp_tone,
  output logic            o_interrupt_progress_output,
  output logic            o_interrupt_progress_oe,
  output logic      [3:0] o_tone_code,
  output logic            o_tone_on,
  output logic            o_single_tone,
  output logic            o_column_tones,
  output logic            o_call_progress_mode
);

  initial begin
    if (BURST_TICKS < 1 || 2 * BURST_TICKS >= (1 << TIMER_W))
      $error("ttr_regs: BURST_TICKS out of range");
  end

  // ----------------------------------------------------------------
  // Host port synchronisation
  // ----------------------------------------------------------------
  logic [7:0] sync_q;
  logic       phi2_lvl;
  logic       cs_n_lvl;
  logic       rw_lvl;
  logic       rs_lvl;
  logic [3:0] data_lvl;
  logic       phi2_prev_reg;

  ttr_sync #(.W(8)) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_phi2, i_cs_n, i_rw, i_register_select_line, i_data}),
    .o_q   (sync_q)
  );

  assign phi2_lvl = sync_q[7];
  assign cs_n_lvl = sync_q[6];
  assign rw_lvl   = sync_q[5];
  assign rs_lvl   = sync_q[4];
  assign data_lvl = sync_q[3:0];

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic sel_b_reg;
  logic access_end;
  logic rd_window;
  logic wr_tx;
  logic wr_ctl;
  logic wr_pri;
  logic wr_sec;
  logic rd_status;

  // An access commits at the falling edge of phi2, after the host has read.
  assign access_end = phi2_prev_reg & ~phi2_lvl & ~cs_n_lvl;
  assign rd_window  = phi2_lvl & ~cs_n_lvl & (rw_lvl == RW_RD);
  assign wr_tx      = access_end & (rs_lvl == RS_DATA) & (rw_lvl == RW_WR);
  assign wr_ctl     = access_end & (rs_lvl == RS_CTRL) & (rw_lvl == RW_WR);
  assign rd_status  = access_end & (rs_lvl == RS_CTRL) & (rw_lvl == RW_RD);
  assign wr_pri     = wr_ctl & ~sel_b_reg;
  assign wr_sec     = wr_ctl & sel_b_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phi2_prev_reg <= 1'b0;
    end else begin
      phi2_prev_reg <= phi2_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------
  logic [3:0] ctl_pri_reg;
  logic [3:0] ctl_sec_reg;
  logic [3:0] tx_code_reg;
  logic [3:0] rx_code_reg;
  logic       rx_take;
  logic       burst_mode;
  logic       cp_mode;
  logic       irq_en;
  logic       test_mode;

  assign cp_mode    = ctl_pri_reg[PRI_CP_MODE];
  assign irq_en     = ctl_pri_reg[PRI_IRQ_EN];
  assign burst_mode = ~ctl_sec_reg[SEC_BURST];
  assign test_mode  = ctl_sec_reg[SEC_TEST] & ~cp_mode;
  // Tone pairs cannot be decoded while the call progress filter is selected.
  assign rx_take    = i_rx_valid & ~cp_mode;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_pri_reg <= CTRL_RESET;
      ctl_sec_reg <= CTRL_RESET;
      sel_b_reg   <= 1'b0;
    end else if (wr_sec) begin
      ctl_sec_reg <= data_lvl;
      sel_b_reg   <= 1'b0;
    end else if (wr_pri) begin
      ctl_pri_reg <= data_lvl;
      sel_b_reg   <= data_lvl[PRI_SEL_SEC];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_code_reg <= CODE_RESET;
      rx_code_reg <= CODE_RESET;
    end else begin
      if (wr_tx) begin
        tx_code_reg <= data_lvl;
      end
      if (rx_take) begin
        rx_code_reg <= i_rx_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // Crystal timebase
  // ----------------------------------------------------------------
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(XTAL_HZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ - XTAL_HZ);
  logic [ACC_W-1:0] acc_reg;
  logic             xtick;

  // Fractional accumulator: one tick per crystal period on average.
  assign xtick = (acc_reg >= ACC_WRAP);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_reg <= '0;
    end else if (xtick) begin
      acc_reg <= acc_reg - ACC_WRAP;
    end else begin
      acc_reg <= acc_reg + ACC_STEP;
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  localparam logic [TIMER_W-1:0] LEN_STD = TIMER_W'(BURST_TICKS - 1);
  localparam logic [TIMER_W-1:0] LEN_EXT = TIMER_W'(2 * BURST_TICKS - 1);
  ttr_burst_t         state_reg;
  ttr_burst_t         state_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic [TIMER_W-1:0] burst_len;
  logic               phase_done;
  logic               txrdy_set;

  // Call progress mode doubles both burst and pause.
  assign burst_len  = cp_mode ? LEN_EXT : LEN_STD;
  assign phase_done = xtick & (timer_reg == '0);
  assign txrdy_set  = (state_reg == TTR_PAUSE) & phase_done & burst_mode;

  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    case (state_reg)
      TTR_IDLE: state_next = TTR_IDLE;
      TTR_TONE: begin
        if (phase_done) begin
          state_next = TTR_PAUSE;
          timer_next = burst_len;
        end else if (xtick) begin
          timer_next = timer_reg - 1'b1;
        end
      end
      TTR_PAUSE: begin
        if (phase_done) begin
          state_next = TTR_IDLE;
        end else if (xtick) begin
          timer_next = timer_reg - 1'b1;
        end
      end
      default: state_next = TTR_IDLE;
    endcase
    if (!burst_mode) begin
      state_next = TTR_IDLE;
    end else if (wr_tx) begin
      state_next = TTR_TONE;
      timer_next = burst_len;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= TTR_IDLE;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic st_irq_reg;
  logic st_txrdy_reg;
  logic st_rxfull_reg;
  logic st_steer_reg;

  // A set arriving in the clearing cycle wins over the read clear.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_irq_reg    <= 1'b0;
      st_txrdy_reg  <= 1'b0;
      st_rxfull_reg <= 1'b0;
      st_steer_reg  <= 1'b0;
    end else begin
      st_irq_reg    <= rx_take | txrdy_set | (st_irq_reg & ~rd_status);
      st_txrdy_reg  <= burst_mode & (txrdy_set | (st_txrdy_reg & ~rd_status));
      st_rxfull_reg <= rx_take | (st_rxfull_reg & ~rd_status);
      if (i_rx_valid) begin
        st_steer_reg <= 1'b0;
      end else if (i_rx_absent) begin
        st_steer_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and pin drivers
  // ----------------------------------------------------------------
  logic [3:0] status_word;
  logic [3:0] read_word;
  logic       pin_low;

  assign status_word = {st_steer_reg, st_rxfull_reg, st_txrdy_reg, st_irq_reg};
  assign read_word   = (rs_lvl == RS_CTRL) ? status_word : rx_code_reg;
  // Test mode shows the steering flag on the pin; call progress mode with irq_en set shows the filter output.
  assign pin_low = test_mode ? ~st_steer_reg :
                   (irq_en & cp_mode) ? ~i_cp_tone :
                   (irq_en & st_irq_reg);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data                      <= 4'h0;
      o_data_oe                   <= 1'b0;
      o_interrupt_progress_output <= 1'b0;
      o_interrupt_progress_oe     <= 1'b0;
    end else begin
      o_data                      <= rd_window ? read_word : 4'h0;
      o_data_oe                   <= rd_window;
      o_interrupt_progress_output <= 1'b0;
      o_interrupt_progress_oe     <= pin_low;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tone_code          <= CODE_RESET;
      o_tone_on            <= 1'b0;
      o_single_tone        <= 1'b0;
      o_column_tones       <= 1'b0;
      o_call_progress_mode <= 1'b0;
    end else begin
      o_tone_code          <= tx_code_reg;
      o_tone_on            <= ctl_pri_reg[PRI_TONE_OUT] &
                              (~burst_mode | (state_reg == TTR_TONE));
      o_single_tone        <= ctl_sec_reg[SEC_SINGLE];
      o_column_tones       <= ctl_sec_reg[SEC_COLUMN];
      o_call_progress_mode <= cp_mode;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_burst_write;
    wr_tx && burst_mode;
  endsequence
  sequence s_tone_phase;
    (state_reg == TTR_TONE) && (timer_reg == $past(burst_len));
  endsequence
  property p_tx_write;
    wr_tx |=> tx_code_reg == $past(data_lvl);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("transmit code not stored");
  property p_cra_route;
    wr_ctl && !sel_b_reg |=> ctl_pri_reg == $past(data_lvl) &&
                             sel_b_reg == $past(data_lvl[PRI_SEL_SEC]);
  endproperty
  a_cra_route: assert property (p_cra_route) else $error("first control write wrong");
  property p_crb_route;
    wr_ctl && sel_b_reg |=> !sel_b_reg && ctl_sec_reg == $past(data_lvl) && $stable(ctl_pri_reg);
  endproperty
  a_crb_route: assert property (p_crb_route) else $error("second control write wrong");
  property p_rx_load;
    rx_take |=> rx_code_reg == $past(i_rx_code) && st_rxfull_reg && st_irq_reg;
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("received code not loaded");
  property p_read_clear;
    rd_status && !rx_take && !txrdy_set |=> !st_irq_reg && !st_rxfull_reg && !st_txrdy_reg;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");
  property p_txrdy_off;
    !burst_mode |=> !st_txrdy_reg;
  endproperty
  a_txrdy_off: assert property (p_txrdy_off) else $error("ready set outside burst mode");
  property p_burst_start;
    s_burst_write |=> s_tone_phase;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst did not start");
  property p_open_drain;
    o_interrupt_progress_output == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("interrupt pin driven high");
  property p_read_drive;
    rd_window |=> o_data_oe && o_data == $past(read_word);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");
  property p_steer;
    i_rx_absent && !i_rx_valid |=> st_steer_reg;
  endproperty
  a_steer: assert property (p_steer) else $error("steering flag not set");
  property p_irq_pin;
    irq_en && !cp_mode && !test_mode && st_irq_reg |=> o_interrupt_progress_oe;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not pulled low");

endmodule
`default_nettype wire

// *** bench/ttr_host_model.sv ***
// Host processor model driving the strobed register port of the tone transceiver.
// Assumes a free-running 10 MHz i_clk; the strobe stands low between accesses.
`timescale 1ns/1ps
`default_nettype none
module ttr_host_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_data,
  input  wire logic       i_data_oe,
  output logic            o_phi2,
  output logic            o_cs_n,
  output logic            o_rw,
  output logic            o_rs,
  output logic      [3:0] o_data
);
  initial begin
    o_phi2 = 1'b0;
    o_cs_n = 1'b1;
    o_rw   = 1'b1;
    o_rs   = 1'b0;
    o_data = 4'h0;
  end

  // One access: strobe high 4 clocks, lines held 6 clocks past its fall.
  // A released data bus shows the inverse of its last value.
  task automatic access(input logic rs, input logic rw, input logic [3:0] wd,
                        input logic cs_n, output logic [3:0] rd, output logic oe);
    @(posedge i_clk);
    #1;
    o_cs_n = cs_n;
    o_rw   = rw;
    o_rs   = rs;
    o_data = rw ? ~o_data : wd;
    o_phi2 = 1'b1;
    repeat (4) @(posedge i_clk);
    #1 o_phi2 = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    rd = i_data;
    oe = i_data_oe;
    repeat (4) @(posedge i_clk);
    #1;
    o_cs_n = 1'b1;
    o_rw   = 1'b1;
    o_data = ~o_data;
  endtask
endmodule
`default_nettype wire

// *** bench/test_ttr_regs.sv ***
// Self-checking bench for the tone transceiver host register bank.
// Assumes the host model of ttr_host_model.sv and a shortened burst count.
`timescale 1ns/1ps
`default_nettype none
module test_ttr_regs;
  import ttr_pkg::*;
  localparam int BT = 4;
  logic       clk, rst, phi2, cs_n, rw, rs, rx_valid, rx_absent, cp_tone;
  logic [3:0] hd, od, rx_code, tone_code;
  logic       oe, irq_d, irq_oe, tone_on, single, column, cpm;
  int         err_count, comparisons, cycles, off;

  ttr_regs #(.BURST_TICKS(BT)) dut (
    .i_clk(clk), .i_rst(rst), .i_phi2(phi2), .i_cs_n(cs_n), .i_rw(rw),
    .i_register_select_line(rs), .i_data(hd), .o_data(od), .o_data_oe(oe),
    .i_rx_valid(rx_valid), .i_rx_code(rx_code), .i_rx_absent(rx_absent),
    .i_cp_tone(cp_tone), .o_interrupt_progress_output(irq_d),
    .o_interrupt_progress_oe(irq_oe), .o_tone_code(tone_code), .o_tone_on(tone_on),
    .o_single_tone(single), .o_column_tones(column), .o_call_progress_mode(cpm));

  ttr_host_model host (
    .i_clk(clk), .i_data(od), .i_data_oe(oe), .o_phi2(phi2), .o_cs_n(cs_n),
    .o_rw(rw), .o_rs(rs), .o_data(hd));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic sel, input logic [3:0] d, input logic ncs = 1'b0);
    logic [3:0] r;
    logic       e;
    host.access(sel, RW_WR, d, ncs, r, e);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rdc(input logic sel, input logic [3:0] exp);
    logic [3:0] r;
    logic       e;
    host.access(sel, RW_RD, 4'h0, 1'b0, r, e);
    check({3'h0, e}, 4'h1);
    check(r, exp);
  endtask

  task automatic pulse(input logic absent, input logic [3:0] code);
    rx_valid = !absent;
    rx_absent = absent;
    rx_code = code;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_absent = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Counts tone-off cycles until the pin pulls low, bounded at 200 clocks.
  task automatic wait_irq();
    off = 0;
    for (int n = 0; n < 200 && irq_oe !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      if (tone_on === 1'b0) off++;
    end
    check({3'h0, irq_oe}, 4'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    rx_valid = 1'b0;
    rx_absent = 1'b0;
    rx_code = 4'h0;
    cp_tone = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check({irq_oe, irq_d, tone_on, cpm}, 4'h0);
    rdc(RS_CTRL, 4'h0);
    wr(RS_CTRL, 4'h8);
    wr(RS_CTRL, 4'h0);
    wr(RS_CTRL, 4'h0);
    wr(RS_CTRL, 4'hA);
    check({cpm, column, single, tone_on}, 4'h8);
    wr(RS_CTRL, 4'hC);
    check({cpm, column, single, tone_on}, 4'hE);
    wr(RS_CTRL, 4'h0);
    check({cpm, column, single, tone_on}, 4'h6);
    wr(RS_CTRL, 4'h2);
    check({cpm, column, single, tone_on}, 4'hE);
    wr(RS_CTRL, 4'h0, 1'b1);
    check({cpm, column, single, tone_on}, 4'hE);
    wr(RS_CTRL, 4'h8);
    wr(RS_CTRL, 4'h0);
    wr(RS_CTRL, 4'h4);
    pulse(1'b0, 4'h9);
    check({2'h0, irq_oe, irq_d}, 4'h2);
    rdc(RS_DATA, 4'h9);
    rdc(RS_CTRL, 4'h5);
    rdc(RS_CTRL, 4'h0);
    check({3'h0, irq_oe}, 4'h0);
    pulse(1'b1, 4'h0);
    rdc(RS_CTRL, 4'h8);
    rdc(RS_CTRL, 4'h8);
    pulse(1'b0, 4'h3);
    rdc(RS_CTRL, 4'h5);
    rdc(RS_DATA, 4'h3);
    wr(RS_CTRL, 4'h5);
    wr(RS_DATA, 4'h7);
    check({tone_on, 3'h0}, 4'h8);
    check(tone_code, 4'h7);
    wait_irq();
    check({3'h0, off >= (BT - 1) * CLK_HZ / XTAL_HZ}, 4'h1);
    check({3'h0, off <= (BT + 1) * CLK_HZ / XTAL_HZ + 2}, 4'h1);
    rdc(RS_CTRL, 4'h3);
    rdc(RS_CTRL, 4'h0);
    wr(RS_DATA, 4'h2);
    check(tone_code, 4'h2);
    wait_irq();
    wr(RS_CTRL, 4'h8);
    wr(RS_CTRL, 4'h1);
    rdc(RS_CTRL, 4'h1);
    rdc(RS_CTRL, 4'h0);
    wr(RS_CTRL, 4'h6);
    cp_tone = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({2'h0, irq_oe, irq_d}, 4'h2);
    cp_tone = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({2'h0, irq_oe, irq_d}, 4'h0);
    pulse(1'b0, 4'h5);
    rdc(RS_CTRL, 4'h0);
    rdc(RS_DATA, 4'h3);
    wr(RS_CTRL, 4'h8);
    wr(RS_CTRL, 4'h3);
    wr(RS_CTRL, 4'h1);
    check({2'h0, irq_oe, tone_on}, 4'h3);
    pulse(1'b1, 4'h0);
    check({2'h0, irq_oe, tone_on}, 4'h1);
    stop_test();
  end
endmodule
`default_nettype wire
